// ==== hw/bitbranch_consts.svh ====
`ifndef BITBRANCH_CONSTS_SVH
`define BITBRANCH_CONSTS_SVH
// What this block does
// - Opcode 1101 with bit 11 zero is jump.
// - Jump target is incremented counter plus 2n.
// - Jump takes two cycles, second is no-op.
// - Opcode 1000 is bit force; bit, bank, file.
// - Bit force sets one bit, flags untouched.
// - Bank bit zero selects the access bank.
// - Bank bit one uses bank select register.
// - Extended set, bank zero, file<=95: frame-indexed.
`define OPC_JUMP 5'h1A
`define OPC_FORCE 4'h8
`define OPC_TSKIP_ONE 4'hA
`define OPC_TSKIP_ZERO 4'hB
`define INDEXED_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_HIGH_BANK 6'h3F
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002
`endif

// ==== hw/bitbranch_pkg.sv ====
package bitbranch_pkg;
	typedef enum logic [1:0] {ST_EXEC = 2'h0, ST_FLUSH = 2'h1} exec_state_t;
	typedef struct packed {
		logic [13:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} file_req_t;
	typedef struct packed {
		logic [15:0] word;
		logic valid;
	} instr_t;
endpackage

// ==== hw/file_addr_resolve.sv ====
`timescale 1ns/10ps
`include "bitbranch_consts.svh"
module file_addr_resolve
	import bitbranch_pkg::*;
(
	// Operand fields
	input wire logic [7:0] file_addr,
	input wire logic bank_bit,
	// Core state
	input wire logic ext_set_en,
	input wire logic [5:0] bank_select_reg,
	input wire logic [13:0] frame_ptr,
	// Result
	output logic [13:0] data_addr
);
	always_comb
	begin
		if (bank_bit)
			data_addr = {bank_select_reg, file_addr};
		else if (ext_set_en && file_addr <= `INDEXED_LIMIT)
			data_addr = frame_ptr + {6'h00, file_addr};
		else if (file_addr < `ACCESS_SPLIT)
			data_addr = {6'h00, file_addr};
		else
			data_addr = {`ACCESS_HIGH_BANK, file_addr};
	end
endmodule

// ==== hw/bitbranch_exec.sv ====
`timescale 1ns/10ps
`include "bitbranch_consts.svh"
module bitbranch_exec
	import bitbranch_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Instruction fetched during the current cycle
	input bitbranch_pkg::instr_t instr,
	// Core context
	input wire logic ext_set_en,
	input wire logic [5:0] bank_select_reg,
	input wire logic [13:0] frame_ptr,
	// Data memory
	output bitbranch_pkg::file_req_t file_req,
	input wire logic [7:0] file_rdata,
	// Flow
	output logic [20:0] program_counter,
	output logic flush,
	output logic unknown_op
);
	import bitbranch_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic rst_s1_r;
	logic rst_n_r;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	exec_state_t state_r;
	logic [15:0] w;
	logic is_jump;
	logic is_force;
	logic is_tzero;
	logic is_tone;
	logic live;
	logic [2:0] bit_sel;
	logic [7:0] mask;
	logic bit_val;
	logic skip_hit;
	logic [13:0] data_addr;
	logic [20:0] jump_target;
	logic [20:0] pc_inc;

	assign w = instr.word;
	assign live = instr.valid && (state_r == ST_EXEC);
	assign is_jump = live && (w[15:11] == `OPC_JUMP);
	assign is_force = live && (w[15:12] == `OPC_FORCE);
	assign is_tzero = live && (w[15:12] == `OPC_TSKIP_ZERO);
	assign is_tone = live && (w[15:12] == `OPC_TSKIP_ONE);
	assign bit_sel = w[11:9];
	assign mask = 8'h01 << bit_sel;
	assign bit_val = |(file_rdata & mask);
	assign skip_hit = (is_tzero && !bit_val) || (is_tone && bit_val);
	assign pc_inc = program_counter + `PC_STEP;
	// Offset is sign-extended, doubled: range -1024..1023 words
	assign jump_target = pc_inc + {{9{w[10]}}, w[10:0], 1'b0};

	file_addr_resolve u_resolve
	(
		.file_addr(w[7:0]),
		.bank_bit(w[8]),
		.ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg),
		.frame_ptr(frame_ptr),
		.data_addr(data_addr)
	);

	// Read and write share the cycle: data returns combinationally
	always_comb
	begin
		file_req.addr = data_addr;
		file_req.re = is_force || is_tzero || is_tone;
		file_req.we = is_force;
		file_req.wdata = file_rdata | mask;
	end

	// Flush is pure state: the word fetched meanwhile never reaches decode
	assign flush = (state_r == ST_FLUSH);
	assign unknown_op = live && !(is_jump || is_force || is_tzero || is_tone);

	////////////////////////////////////////////////////////////////////////
	// Only jumps and taken skips open a refill cycle
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			state_r <= ST_EXEC;
		else
			case (state_r)
				ST_EXEC:
					if (is_jump || skip_hit)
						state_r <= ST_FLUSH;
				ST_FLUSH:
					state_r <= ST_EXEC;
				default:
					state_r <= ST_EXEC;
			endcase
	end

	// Counter loads the target on a jump, steps on every other valid word and on the refill cycle, so it stays aligned
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			program_counter <= `PC_RESET;
		else if (is_jump)
			program_counter <= jump_target;
		else if (instr.valid || flush)
			program_counter <= pc_inc;
	end

	////////////////////////////////////////////////////////////////////////
	AST_JUMP_TARGET: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_jump |=> program_counter == $past(jump_target))
		else $error("jump target wrong");
	AST_JUMP_FLUSH: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_jump |=> flush ##1 !flush)
		else $error("jump not two cycles");
	AST_FORCE_WRITE: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_force |-> file_req.we && file_req.wdata[bit_sel]
		&& ((file_req.wdata & ~mask) == (file_rdata & ~mask)))
		else $error("bit force data wrong");
	AST_FORCE_RMW: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_force |-> file_req.re ##1 !flush)
		else $error("bit force not single cycle");
	AST_DECODE_JUMP: assert property (@(posedge clk) disable iff (!rst_n_r)
		(live && w[15:11] == 5'h1A) |-> is_jump && !is_force)
		else $error("jump decode wrong");
	AST_DECODE_FORCE: assert property (@(posedge clk) disable iff (!rst_n_r)
		(live && w[15:12] == 4'h8) |-> file_req.we)
		else $error("force decode wrong");
	AST_BANKED: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_force && w[8]) |-> file_req.addr == {bank_select_reg, w[7:0]})
		else $error("banked address wrong");
	AST_INDEXED: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_force && !w[8] && ext_set_en && w[7:0] <= 8'h5F)
		|-> file_req.addr == frame_ptr + {6'h00, w[7:0]})
		else $error("indexed address wrong");
	AST_ACCESS: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_force && !w[8] && !ext_set_en && w[7:0] < 8'h60)
		|-> file_req.addr == {6'h00, w[7:0]})
		else $error("access address wrong");
	AST_SKIP: assert property (@(posedge clk) disable iff (!rst_n_r)
		((is_tzero && !bit_val) || (is_tone && bit_val)) |=> flush)
		else $error("skip missed");

	////////////////////////////////////////////////////////////////////////
	// Side effects of every decoded operation; upper access bank form for bit force, banked and indexed forms for bit tests
	AST_JUMP_BIT11: assert property (@(posedge clk) disable iff (!rst_n_r)
		(live && w[15:12] == 4'hD && w[11]) |-> !is_jump)
		else $error("jump decoded with bit 11 set");

	AST_JUMP_QUIET: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_jump |-> !file_req.re && !file_req.we)
		else $error("jump touched data memory");

	AST_FLUSH_SINGLE: assert property (@(posedge clk) disable iff (!rst_n_r)
		flush |=> !flush)
		else $error("refill longer than one cycle");

	AST_FLUSH_IDLE: assert property (@(posedge clk) disable iff (!rst_n_r)
		flush |-> !file_req.re && !file_req.we && !unknown_op)
		else $error("refill cycle did work");

	AST_FLUSH_STEP: assert property (@(posedge clk) disable iff (!rst_n_r)
		flush |=> program_counter == $past(pc_inc))
		else $error("refill cycle did not step counter");

	AST_ACCESS_HIGH: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_force && !w[8] && w[7:0] >= 8'h60) |-> file_req.addr == {6'h3F, w[7:0]})
		else $error("upper access bank address wrong");

	AST_ACCESS_NO_EXT: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_force && !w[8] && !ext_set_en)
		|-> (file_req.addr[13:8] == 6'h00) || (file_req.addr[13:8] == 6'h3F))
		else $error("access bank left without extended set");

	AST_TEST_BANKED: assert property (@(posedge clk) disable iff (!rst_n_r)
		((is_tzero || is_tone) && w[8]) |-> file_req.addr == {bank_select_reg, w[7:0]})
		else $error("bit test banked address wrong");

	AST_TEST_INDEXED: assert property (@(posedge clk) disable iff (!rst_n_r)
		((is_tzero || is_tone) && !w[8] && ext_set_en && w[7:0] <= 8'h5F)
		|-> file_req.addr == frame_ptr + {6'h00, w[7:0]})
		else $error("bit test indexed address wrong");

	AST_FORCE_STEP: assert property (@(posedge clk) disable iff (!rst_n_r)
		is_force |=> program_counter == $past(pc_inc))
		else $error("bit force did not step counter");

	AST_TEST_READ: assert property (@(posedge clk) disable iff (!rst_n_r)
		(is_tzero || is_tone) |-> file_req.re && !file_req.we)
		else $error("bit test wrote data memory");

	AST_NO_SKIP: assert property (@(posedge clk) disable iff (!rst_n_r)
		((is_tzero && bit_val) || (is_tone && !bit_val)) |=> !flush)
		else $error("skip taken on mismatch");

	AST_SKIP_STEP: assert property (@(posedge clk) disable iff (!rst_n_r)
		skip_hit |=> program_counter == $past(pc_inc))
		else $error("skip did not step counter");

	AST_UNKNOWN_QUIET: assert property (@(posedge clk) disable iff (!rst_n_r)
		unknown_op
		|-> !file_req.re && !file_req.we ##1 !flush)
		else $error("unknown word had an effect");

	// Main scenarios reached
	COV_JUMP: cover property (@(posedge clk) disable iff (!rst_n_r) is_jump);
	COV_FORCE: cover property (@(posedge clk) disable iff (!rst_n_r) is_force && w[8]);
	COV_SKIP0: cover property (@(posedge clk) disable iff (!rst_n_r) is_tzero ##1 flush);
	COV_SKIP1: cover property (@(posedge clk) disable iff (!rst_n_r) is_tone ##1 !flush);
	COV_INDEXED: cover property (@(posedge clk) disable iff (!rst_n_r)
		is_force && !w[8] && ext_set_en && w[7:0] <= 8'h5F);
endmodule

// ==== test/branch_and_bit_set_execution_tb.sv ====
`timescale 1ns/10ps
module branch_and_bit_set_execution_tb;
	import bitbranch_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	instr_t instr = '0;
	logic ext_set_en = 1'b0;
	logic [5:0] bank_select_reg = 6'h15;
	logic [13:0] frame_ptr = 14'h0123;
	logic [7:0] file_rdata = 8'h00;
	file_req_t file_req;
	logic [20:0] program_counter;
	logic flush;
	logic unknown_op;
	int bad_count = 0;
	int comparisons = 0;
	logic [20:0] pc0;
	always #50 clk = ~clk;
	bitbranch_exec i_dut (.clk(clk), .nrst(nrst), .instr(instr), .ext_set_en(ext_set_en),
		.bank_select_reg(bank_select_reg), .frame_ptr(frame_ptr), .file_req(file_req),
		.file_rdata(file_rdata), .program_counter(program_counter), .flush(flush),
		.unknown_op(unknown_op));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [20:0] got, input logic [20:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Word is held for one cycle, outputs looked at once settled
	task put(input logic [15:0] w, input logic v);
		@(posedge clk);
		instr <= '{word: w, valid: v};
		@(negedge clk);
	endtask
	task t_jump(input logic [10:0] n);
		put({5'h1A, n}, 1'b1);
		pc0 = program_counter;
		chk(21'(unknown_op), 21'h0);
		// A second jump during the refill must be dropped
		put({5'h1A, n}, 1'b1);
		chk(program_counter, pc0 + 21'h2 + {{9{n[10]}}, n, 1'b0});
		chk(21'(flush), 21'h1);
		put(16'h0000, 1'b0);
		chk(21'(flush), 21'h0);
		chk(program_counter, pc0 + 21'h4 + {{9{n[10]}}, n, 1'b0});
		put(16'hD800, 1'b1);
		chk(21'(unknown_op), 21'h1);
		put(16'h0000, 1'b0);
		chk(21'(flush), 21'h0);
		$display("jump %h done", n);
	endtask
	task t_force(input logic [2:0] b, input logic a, input logic [7:0] f, input logic x,
		input logic [13:0] ea);
		@(posedge clk);
		ext_set_en <= x;
		file_rdata <= 8'h5A & ~(8'h01 << b);
		put({4'h8, b, a, f}, 1'b1);
		chk(21'(file_req.addr), 21'(ea));
		chk(21'({file_req.re, file_req.we}), 21'h3);
		chk(21'(file_req.wdata), 21'(8'h5A | (8'h01 << b)));
		pc0 = program_counter;
		put(16'h0000, 1'b0);
		chk(program_counter, pc0 + 21'h2);
		chk(21'(flush), 21'h0);
		$display("force %h %h done", f, b);
	endtask
	task t_skip(input logic [3:0] op, input logic [7:0] rd, input logic ef);
		@(posedge clk);
		file_rdata <= rd;
		put({op, 3'h4, 1'b1, 8'h20}, 1'b1);
		chk(21'(file_req.addr), 21'h1520);
		chk(21'({file_req.re, file_req.we}), 21'h2);
		put(16'h0000, 1'b0);
		chk(21'(flush), 21'(ef));
		put(16'h0000, 1'b0);
		$display("skip %h %h done", op, rd);
	endtask
	task close_out;
		$display("comparisons %0d bad %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk);
		chk(program_counter, 21'h0);
		nrst <= 1'b1;
		// Two synchroniser stages before the core sees release
		repeat (3) @(posedge clk);
		t_jump(11'h005);
		t_jump(11'h400);
		t_jump(11'h3FF);
		t_force(3'h7, 1'b1, 8'h0A, 1'b0, 14'h150A);
		t_force(3'h0, 1'b0, 8'h5F, 1'b0, 14'h005F);
		t_force(3'h3, 1'b0, 8'h60, 1'b0, 14'h3F60);
		t_force(3'h5, 1'b0, 8'h5F, 1'b1, 14'h0182);
		t_force(3'h2, 1'b0, 8'h60, 1'b1, 14'h3F60);
		t_force(3'h6, 1'b1, 8'h10, 1'b1, 14'h1510);
		t_skip(4'hB, 8'hEF, 1'b1);
		t_skip(4'hB, 8'h10, 1'b0);
		t_skip(4'hA, 8'h10, 1'b1);
		t_skip(4'hA, 8'hEF, 1'b0);
		close_out();
	end
endmodule
